// ===== verilog/lcf_pkg.sv
// Register map, reset values and request carrier of the fault bank.
// Assumes a serial front end that turns host frames into byte requests.
package lcf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OPEN_DET_MASK_CH16_23 = 8'h6C;
  localparam logic [7:0] OPEN_DET_MASK_CH24_31 = 8'h6D;
  localparam logic [7:0] OPEN_DET_MASK_CH32_35 = 8'h6E;
  localparam logic [7:0] SHORT_DET_MASK_CH0_7 = 8'h6F;
  localparam logic [7:0] SHORT_DET_MASK_CH8_15 = 8'h70;
  localparam logic [7:0] SHORT_DET_MASK_CH16_23 = 8'h71;
  localparam logic [7:0] SHORT_DET_MASK_CH24_31 = 8'h74;
  localparam logic [7:0] SHORT_DET_MASK_CH32_35 = 8'h75;
  localparam logic [7:0] OPEN_FAULT_STATUS_CH0_7 = 8'h76;
  localparam logic [7:0] OPEN_FAULT_STATUS_CH8_15 = 8'h77;
  localparam logic [7:0] OPEN_FAULT_STATUS_CH16_23 = 8'h78;
  localparam logic [7:0] OPEN_FAULT_STATUS_CH24_31 = 8'h79;

  // ==========================================================
  // Field layout and reset values
  localparam int NIBBLE_MSB = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Byte request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcf_reg_req_t;

endpackage : lcf_pkg

// ===== verilog/lcf_sticky_bank.sv
// Sticky per-channel fault status bits with detection masks.
// Assumes event, mask and clear are synchronous to sys_clk.
`timescale 1ns/100ps
module lcf_sticky_bank #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] faultEvent,
  input wire logic [WIDTH-1:0] faultMask,
  input wire logic [WIDTH-1:0] faultClear,
  output logic [WIDTH-1:0] faultStatus
);

  // ==========================================================
  // Status update
  // Set beats clear so a fault in the clearing cycle survives
  wire logic [WIDTH-1:0] setVec = faultEvent & ~faultMask;
  wire logic [WIDTH-1:0] next_faultStatus =
    (faultStatus & ~faultClear) | setVec;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("lcf_sticky_bank: WIDTH must be positive");
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      faultStatus <= '0;
    end else begin
      faultStatus <= next_faultStatus;
    end
  end

endmodule : lcf_sticky_bank

// ===== verilog/lcf_fault_bank.sv
// Per-channel open/short mask registers and open fault status bytes.
// Assumes byte requests arrive one per cycle from the serial front end.
`timescale 1ns/100ps

// What this block does
// - Open mask byte 6C covers channels 16-23
// - Open mask byte 6D covers channels 24-31
// - Open mask 6E nibble, channels 32-35, reserved high
// - Open mask bit one means masked
// - Short mask byte 6F covers channels 0-7
// - Short mask byte 70 covers channels 8-15
// - Short mask byte 71 covers channels 16-23
// - Short mask byte 74 covers channels 24-31
// - Short mask 75 nibble, channels 32-35, reserved high
// - Short mask bit one means masked
// - Open fault byte 76 reports channels 0-7
// - Open fault byte 77 reports channels 8-15
// - Open fault byte 78 reports channels 16-23
// - Open fault byte 79 reports channels 24-31
// - Fault bit one means open detected
module lcf_fault_bank #(
  parameter int NUM_CH = 36
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire lcf_pkg::lcf_reg_req_t regReq,
  input wire logic [15:0] openMaskLow,
  input wire logic [35:0] openDetect,
  input wire logic [35:0] shortDetect,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [19:0] openMaskHigh,
  output logic [35:0] shortMask,
  output logic [31:0] openFaultStatus,
  output logic openFaultAny,
  output logic shortFaultAny
);

  generate
    if (NUM_CH != 36) begin : g_bad
      $error("lcf_fault_bank: map is fixed at 36 channels");
    end
  endgenerate

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  wire logic wr = regReq.wr;
  wire logic rd = regReq.rd;
  wire logic [7:0] ad = regReq.addr;
  wire logic [7:0] wd = regReq.wdata;

  wire logic wrOm2 = wr && hit(ad, lcf_pkg::OPEN_DET_MASK_CH16_23);
  wire logic wrOm3 = wr && hit(ad, lcf_pkg::OPEN_DET_MASK_CH24_31);
  wire logic wrOm4 = wr && hit(ad, lcf_pkg::OPEN_DET_MASK_CH32_35);
  wire logic wrSm0 = wr && hit(ad, lcf_pkg::SHORT_DET_MASK_CH0_7);
  wire logic wrSm1 = wr && hit(ad, lcf_pkg::SHORT_DET_MASK_CH8_15);
  wire logic wrSm2 = wr && hit(ad, lcf_pkg::SHORT_DET_MASK_CH16_23);
  wire logic wrSm3 = wr && hit(ad, lcf_pkg::SHORT_DET_MASK_CH24_31);
  wire logic wrSm4 = wr && hit(ad, lcf_pkg::SHORT_DET_MASK_CH32_35);
  wire logic wrOf0 = wr && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH0_7);
  wire logic wrOf1 = wr && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH8_15);
  wire logic wrOf2 = wr && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH16_23);
  wire logic wrOf3 = wr && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH24_31);

  // ==========================================================
  // Mask registers
  wire logic [3:0] wdNib = wd[lcf_pkg::NIBBLE_MSB:0];
  wire logic [19:0] next_openMaskHigh = {
    wrOm4 ? wdNib : openMaskHigh[19:16],
    wrOm3 ? wd : openMaskHigh[15:8],
    wrOm2 ? wd : openMaskHigh[7:0]
  };
  wire logic [35:0] next_shortMask = {
    wrSm4 ? wdNib : shortMask[35:32],
    wrSm3 ? wd : shortMask[31:24],
    wrSm2 ? wd : shortMask[23:16],
    wrSm1 ? wd : shortMask[15:8],
    wrSm0 ? wd : shortMask[7:0]
  };

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      openMaskHigh <= {{2{lcf_pkg::RESET_BYTE}}, lcf_pkg::RESET_BYTE[3:0]};
      shortMask <= {{4{lcf_pkg::RESET_BYTE}}, lcf_pkg::RESET_BYTE[3:0]};
    end else begin
      openMaskHigh <= next_openMaskHigh;
      shortMask <= next_shortMask;
    end
  end

  // ==========================================================
  // Open fault status
  // Writing a one clears that bit; a zero leaves it alone
  wire logic [31:0] openMaskAll = {openMaskHigh[15:0], openMaskLow};
  wire logic [31:0] statusClear = {
    wrOf3 ? wd : 8'h00, wrOf2 ? wd : 8'h00,
    wrOf1 ? wd : 8'h00, wrOf0 ? wd : 8'h00
  };

  lcf_sticky_bank #(
    .WIDTH(32)
  ) u_open_status (
    .sys_clk(sys_clk),
    .rst(rst),
    .faultEvent(openDetect[31:0]),
    .faultMask(openMaskAll),
    .faultClear(statusClear),
    .faultStatus(openFaultStatus)
  );

  // ==========================================================
  // Summaries
  // Channels 32-35 have no byte here, so they feed the summary live
  wire logic [3:0] openTopLive = openDetect[35:32] & ~openMaskHigh[19:16];
  wire logic next_openFaultAny = (|openFaultStatus) || (|openTopLive);
  wire logic next_shortFaultAny = |(shortDetect & ~shortMask);

  // ==========================================================
  // Read path
  wire logic [7:0] readMux =
    hit(ad, lcf_pkg::OPEN_DET_MASK_CH16_23) ? openMaskHigh[7:0] :
    hit(ad, lcf_pkg::OPEN_DET_MASK_CH24_31) ? openMaskHigh[15:8] :
    hit(ad, lcf_pkg::OPEN_DET_MASK_CH32_35) ?
      {4'h0, openMaskHigh[19:16]} :
    hit(ad, lcf_pkg::SHORT_DET_MASK_CH0_7) ? shortMask[7:0] :
    hit(ad, lcf_pkg::SHORT_DET_MASK_CH8_15) ? shortMask[15:8] :
    hit(ad, lcf_pkg::SHORT_DET_MASK_CH16_23) ? shortMask[23:16] :
    hit(ad, lcf_pkg::SHORT_DET_MASK_CH24_31) ? shortMask[31:24] :
    hit(ad, lcf_pkg::SHORT_DET_MASK_CH32_35) ?
      {4'h0, shortMask[35:32]} :
    hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH0_7) ?
      openFaultStatus[7:0] :
    hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH8_15) ?
      openFaultStatus[15:8] :
    hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH16_23) ?
      openFaultStatus[23:16] :
    hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH24_31) ?
      openFaultStatus[31:24] :
    lcf_pkg::UNMAPPED_READ;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData <= lcf_pkg::RESET_BYTE;
      rdValid <= 1'b0;
      openFaultAny <= 1'b0;
      shortFaultAny <= 1'b0;
    end else begin
      rdData <= rd ? readMux : rdData;
      rdValid <= rd;
      openFaultAny <= next_openFaultAny;
      shortFaultAny <= next_shortFaultAny;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  maskResetZero_a: assert property (
    $past(rst) |-> openMaskHigh == 20'h00000 && shortMask == 36'h0)
    else $error("mask registers not zero after reset");

  openMask24Write_a: assert property (
    wrOm3 |=> openMaskHigh[15:8] == $past(wd))
    else $error("open mask 24-31 write lost");

  openMaskNibble_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_DET_MASK_CH32_35) |=>
      rdData == {4'h0, openMaskHigh[19:16]})
    else $error("open mask 32-35 read wrong");

  shortMask0Write_a: assert property (
    wrSm0 ##1 !wrSm0 |=> shortMask[7:0] == $past(wd, 2))
    else $error("short mask 0-7 write not kept");

  shortMask24Addr_a: assert property (
    wrSm3 |=> shortMask[31:24] == $past(wd) &&
      shortMask[23:16] == $past(shortMask[23:16]))
    else $error("short mask 24-31 write misplaced");

  shortMaskNibble_a: assert property (
    wrSm4 |=> shortMask[35:32] == $past(wdNib))
    else $error("short mask 32-35 write lost");

  shortSummary_a: assert property (
    (shortDetect & ~shortMask) == 36'h0 |=> !shortFaultAny)
    else $error("masked short raised summary");

  openFaultSet_a: assert property (
    openDetect[5] && !openMaskLow[5] |=> openFaultStatus[5])
    else $error("open fault not latched");

  openFaultRead_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH0_7) |=>
      rdValid && rdData == $past(openFaultStatus[7:0]))
    else $error("open fault 0-7 read wrong");

  openFaultRead24_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH24_31) |=>
      rdData == $past(openFaultStatus[31:24]))
    else $error("open fault 24-31 read wrong");

  maskedNoSet_a: assert property (
    !openFaultStatus[16] && openMaskHigh[0] |=> !openFaultStatus[16])
    else $error("masked channel set its open fault");

  stickyHold_a: assert property (
    openFaultStatus[20] && !(wrOf2 && wd[4]) |=> openFaultStatus[20])
    else $error("open fault 20 dropped without clear");

  // ==========================================================
  // Further checks on writes, reads, masks and summaries
  // Kept as small per-byte cases so a failure names its register

  openMask16Write_a: assert property (
    wrOm2 |=> openMaskHigh[7:0] == $past(wd))
    else $error("open mask 16-23 write lost");

  openMask16Read_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_DET_MASK_CH16_23) |=>
      rdData == $past(openMaskHigh[7:0]))
    else $error("open mask 16-23 read wrong");

  openMaskNibWrite_a: assert property (
    wrOm4 |=> openMaskHigh[19:16] == $past(wdNib))
    else $error("open mask 32-35 write lost");

  openMaskOff_a: assert property (
    openDetect[24] && !openMaskHigh[8] |=> openFaultStatus[24])
    else $error("unmasked open fault 24 not latched");

  shortMask8Write_a: assert property (
    wrSm1 |=> shortMask[15:8] == $past(wd))
    else $error("short mask 8-15 write lost");

  shortMask16Write_a: assert property (
    wrSm2 |=> shortMask[23:16] == $past(wd))
    else $error("short mask 16-23 write lost");

  shortMask24Read_a: assert property (
    rd && hit(ad, lcf_pkg::SHORT_DET_MASK_CH24_31) |=>
      rdData == $past(shortMask[31:24]))
    else $error("short mask 24-31 read wrong");

  shortNibbleRead_a: assert property (
    rd && hit(ad, lcf_pkg::SHORT_DET_MASK_CH32_35) |=>
      rdData == {4'h0, $past(shortMask[35:32])})
    else $error("short mask 32-35 read wrong");

  shortSummaryOn_a: assert property (
    (shortDetect & ~shortMask) != 36'h0 |=> shortFaultAny)
    else $error("unmasked short missed in summary");

  openFaultRead8_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH8_15) |=>
      rdValid && rdData == $past(openFaultStatus[15:8]))
    else $error("open fault 8-15 read wrong");

  openFaultClear_a: assert property (
    openFaultStatus[8] && wrOf1 && wd[0] &&
      !(openDetect[8] && !openMaskLow[8]) |=> !openFaultStatus[8])
    else $error("open fault 8 not cleared by write");

  openFaultRead16_a: assert property (
    rd && hit(ad, lcf_pkg::OPEN_FAULT_STATUS_CH16_23) |=>
      rdValid && rdData == $past(openFaultStatus[23:16]))
    else $error("open fault 16-23 read wrong");

  openFaultSet31_a: assert property (
    openDetect[31] && !openMaskHigh[15] |=> openFaultStatus[31])
    else $error("open fault 31 not latched");

  setBeatsClear_a: assert property (
    openDetect[0] && !openMaskLow[0] && wrOf0 && wd[0] |=>
      openFaultStatus[0])
    else $error("clear beat a new open fault");

  openTopSummary_a: assert property (
    (openDetect[35:32] & ~openMaskHigh[19:16]) != 4'h0 |=> openFaultAny)
    else $error("live open on 32-35 missed in summary");

  openQuietSummary_a: assert property (
    openFaultStatus == 32'h0 &&
      (openDetect[35:32] & ~openMaskHigh[19:16]) == 4'h0 |=> !openFaultAny)
    else $error("open summary raised with nothing unmasked");

  readPulse_a: assert property (
    rd |=> rdValid)
    else $error("read not answered");

  readPulseEnd_a: assert property (
    !rd |=> !rdValid)
    else $error("read answer longer than one cycle");

  readHold_a: assert property (
    !rd |=> $stable(rdData))
    else $error("read data moved without a read");

  maskHold_a: assert property (
    !wr |=> $stable(openMaskHigh) && $stable(shortMask))
    else $error("mask changed without a write");

  statusResetZero_a: assert property (
    $past(rst) |-> openFaultStatus == 32'h0 && !rdValid)
    else $error("status or answer not clear after reset");

endmodule : lcf_fault_bank

// ===== testbench/lcf_host_model.sv
// Host model: issues single byte register requests.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/100ps
module lcf_host_model (
  input wire logic sys_clk,
  output lcf_pkg::lcf_reg_req_t regReq
);
  // ==========================================
  // Request driving
  initial regReq = '0;
  // Request held one edge; no release so back to back works
  task automatic put(input lcf_pkg::lcf_reg_req_t r);
    regReq <= r;
    @(posedge sys_clk);
  endtask : put
  task automatic idle;
    regReq <= '0;
    @(posedge sys_clk);
  endtask : idle
endmodule : lcf_host_model

// ===== testbench/lcf_fault_bank_tb.sv
// Self-checking bench for the fault mask and status bank.
// Assumes the host model in lcf_host_model.sv.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module lcf_fault_bank_tb;
  // ==========================================
  // Signals
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  lcf_pkg::lcf_reg_req_t regReq;
  logic [15:0] openMaskLow = '0;
  logic [35:0] openDetect = '0;
  logic [35:0] shortDetect = '0;
  logic [7:0] rdData;
  logic rdValid;
  logic [19:0] openMaskHigh;
  logic [35:0] shortMask;
  logic [31:0] openFaultStatus;
  logic openFaultAny;
  logic shortFaultAny;
  logic [7:0] expQ[$];
  logic [7:0] eb;
  logic [7:0] shadow [256];
  logic [35:0] det;
  logic [31:0] expSt = '0;
  logic [35:0] expSm;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] addrs [12] = '{8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71,
    8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79};
  always #5 sysClk = ~sysClk;
  lcf_host_model host (.sys_clk(sysClk), .regReq(regReq));
  lcf_fault_bank dut (.sys_clk(sysClk), .rst(rst), .regReq(regReq),
    .openMaskLow(openMaskLow), .openDetect(openDetect),
    .shortDetect(shortDetect), .rdData(rdData), .rdValid(rdValid),
    .openMaskHigh(openMaskHigh), .shortMask(shortMask),
    .openFaultStatus(openFaultStatus), .openFaultAny(openFaultAny),
    .shortFaultAny(shortFaultAny));
  // ==========================================
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a inside {[8'h6C:8'h71], 8'h74, 8'h75})
      shadow[a] = (a == 8'h6E || a == 8'h75) ? (d & 8'h0F) : d;
    host.put('{1'b1, 1'b0, a, d});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    expQ.push_back(shadow[a]);
    host.put('{1'b0, 1'b1, a, 8'h00});
  endtask : rd
  task automatic gap;
    host.idle();
    repeat (3) @(posedge sysClk);
  endtask : gap
  task automatic end_of_test;
    $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ==========================================
  // Read monitor: one note per answered read
  always @(posedge sysClk) if (rdValid === 1'b1) begin
    if (expQ.size() == 0) `CHK("rdValid", 1'b0, rdValid)
    else begin
      eb = expQ.pop_front();
      `CHK("rdData", eb, rdData)
    end
  end
  // Watchdog well beyond the hundred or so cycles needed
  initial begin
    repeat (3000) @(posedge sysClk);
    n_mismatch++;
    end_of_test();
  end
  // ==========================================
  // Tests
  initial begin
    void'($urandom(34));
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (3) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    foreach (addrs[i]) rd(addrs[i]);
    gap();
    `CHK("masks", 56'h0, {openMaskHigh, shortMask})
    $display("test reset done");
    for (int i = 0; i < 8; i++) wr(addrs[i], 8'($urandom()));
    wr(8'h72, 8'hFF);
    rd(8'h72);
    for (int i = 0; i < 8; i++) rd(addrs[i]);
    openMaskLow <= 16'($urandom());
    gap();
    `CHK("openMaskHigh", {shadow[8'h6E][3:0], shadow[8'h6D], shadow[8'h6C]},
      openMaskHigh)
    `CHK("shortMask", {shadow[8'h75][3:0], shadow[8'h74], shadow[8'h71],
      shadow[8'h70], shadow[8'h6F]}, shortMask)
    $display("test masks done");
    for (int j = 0; j < 2; j++) begin
      det = j ? 36'({$urandom(), $urandom()}) : {shadow[8'h6E][3:0],
        shadow[8'h6D], shadow[8'h6C], openMaskLow};
      expSt |= det[31:0] & ~{shadow[8'h6D], shadow[8'h6C], openMaskLow};
      openDetect <= det;
      @(posedge sysClk);
      openDetect <= '0;
      gap();
      `CHK("status", expSt, openFaultStatus)
      `CHK("openAny", |expSt, openFaultAny)
    end
    for (int k = 0; k < 4; k++) shadow[8'h76 + k] = expSt[8 * k +: 8];
    for (int k = 0; k < 4; k++) rd(8'h76 + 8'(k));
    for (int k = 0; k < 4; k++) wr(8'h76 + 8'(k), 8'hFF);
    gap();
    `CHK("cleared", 33'h0, {openFaultAny, openFaultStatus})
    openMaskLow <= '0;
    openDetect <= 36'h1;
    wr(8'h76, 8'h01);
    openDetect <= '0;
    gap();
    `CHK("setWins", 33'h1_0000_0001, {openFaultAny, openFaultStatus})
    $display("test open faults done");
    expSm = {shadow[8'h75][3:0], shadow[8'h74], shadow[8'h71],
      shadow[8'h70], shadow[8'h6F]};
    for (int j = 0; j < 4; j++) begin
      det = j ? 36'({$urandom(), $urandom()}) : expSm;
      shortDetect <= det;
      @(posedge sysClk);
      shortDetect <= '0;
      @(negedge sysClk);
      `CHK("shortAny", |(det & ~expSm), shortFaultAny)
      @(posedge sysClk);
    end
    gap();
    `CHK("pending", 0, expQ.size())
    $display("test short faults done");
    rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    foreach (shadow[i]) shadow[i] = 8'h00;
    foreach (addrs[i]) rd(addrs[i]);
    gap();
    `CHK("resetAgain", 89'h0,
      {openMaskHigh, shortMask, openFaultStatus, openFaultAny})
    `CHK("pendingAgain", 0, expQ.size())
    $display("test reset again done");
    end_of_test();
  end
endmodule : lcf_fault_bank_tb
